// ===== logic/mdu_pkg.sv
// Shared constants and types for the arithmetic coprocessor
package mdu_pkg;
  // Register select codes on the special-register port
  localparam logic [2:0] SEL_MD0  = 3'h0;
  localparam logic [2:0] SEL_MD1  = 3'h1;
  localparam logic [2:0] SEL_MD2  = 3'h2;
  localparam logic [2:0] SEL_MD3  = 3'h3;
  localparam logic [2:0] SEL_MD4  = 3'h4;
  localparam logic [2:0] SEL_MD5  = 3'h5;
  localparam logic [2:0] SEL_CTRL = 3'h6;
  // Field positions inside arith_control
  localparam int ERR_BIT = 7;
  localparam int OVF_BIT = 6;
  localparam int SLR_BIT = 5;
  localparam int SC_MSB  = 4;
  // Reset values
  localparam logic [7:0] MD_RST = 8'h00;
  localparam logic [4:0] SC_RST = 5'h00;
  // Timing: machine cycles allowed, and shift bits per cycle
  localparam int         DIV32_MC   = 6;
  localparam int         DIV16_MC   = 4;
  localparam int         MUL_MC     = 4;
  localparam int         SHIFT_MC   = 6;
  localparam logic [2:0] FIRST_STEP = 3'h4;
  localparam logic [2:0] NEXT_STEP  = 3'h6;
  localparam logic [4:0] NORM_MAX   = 5'h1F;
  // Write-order tracker states; nine of them, so the code needs four bits
  typedef enum logic [3:0] {
    W_IDLE, W_0, W_01, W_012, W_0123, W_01234, W_014, W_04, W_041
  } mdu_wseq_t;
  // Shift engine states
  typedef enum logic [1:0] {R_IDLE, R_NORM, R_SHIFT} mdu_run_t;
  // Operation kinds
  typedef enum logic [2:0] {OP_NONE, OP_DIV32, OP_DIV16, OP_MUL, OP_SHIFT} mdu_op_t;
endpackage

// ===== logic/mdu_unit.sv
// Arithmetic coprocessor: multiply, divide, normalize and shift on byte registers
`timescale 1ns/10ps
module mdu_unit
  import mdu_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic [2:0] reg_sel,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] rd_data
);

  // One normalize pass: up to n left shifts while MSB clear
  function automatic logic [36:0] norm_step(input logic [31:0] v,
                                            input logic [4:0]  c,
                                            input logic [2:0]  n);
    logic [31:0] vv;
    logic [4:0]  cc;
    vv = v;
    cc = c;
    for (int i = 0; i < 6; i++)
    begin
      // Stop at MSB set or at the count ceiling
      if (3'(i) < n && !vv[31] && cc != NORM_MAX)
      begin
        vv = {vv[30:0], 1'b0};
        cc = cc + 5'h01;
      end
    end
    return {vv, cc};
  endfunction

  // Next write-order state for a byte write
  function automatic mdu_wseq_t seq_next(input mdu_wseq_t s,
                                         input logic [2:0] sel);
    mdu_wseq_t r;
    r = W_IDLE;
    case (s)
      W_0:     r = (sel == SEL_MD1) ? W_01 : (sel == SEL_MD4) ? W_04 : W_IDLE;
      W_01:    r = (sel == SEL_MD2) ? W_012 : (sel == SEL_MD4) ? W_014 : W_IDLE;
      W_012:   r = (sel == SEL_MD3) ? W_0123 : W_IDLE;
      W_0123:  r = (sel == SEL_MD4) ? W_01234 : W_IDLE;
      W_04:    r = (sel == SEL_MD1) ? W_041 : W_IDLE;
      default: r = W_IDLE;
    endcase
    return r;
  endfunction

  logic [7:0]  md [0:5];          // Operand and result bytes
  logic [7:0]  next_md [0:5];     // Next values of the bytes
  mdu_wseq_t   wseq;              // Write-order tracker
  mdu_run_t    run;               // Shift engine state
  mdu_op_t     pend;              // Multiply/divide waiting to run
  mdu_op_t     mon_op;            // Operation whose read-out is watched
  logic        armed;             // Monitoring active
  logic        err;               // calc_error_flag
  logic        ovf;               // calc_overflow_flag
  logic        shift_right_select;               // shift_right_select
  logic [4:0]  sc;                // shift_count_field
  logic [4:0]  rem;               // Shifts left to do, or normalize count
  logic        first;             // First cycle of a shift run

  // Access decode
  wire         wr_md0   = wr_en && reg_sel == SEL_MD0;
  wire         wr_md5   = wr_en && reg_sel == SEL_MD5;
  wire         wr_ctrl  = wr_en && reg_sel == SEL_CTRL;
  wire         rd_ctrl  = rd_en && reg_sel == SEL_CTRL;
  wire         low_acc  = (wr_en || rd_en) && reg_sel <= SEL_MD3;
  wire         busy     = run != R_IDLE;
  wire [31:0]  acc      = {md[3], md[2], md[1], md[0]};
  wire [15:0]  dvs      = {md[5], md[4]};

  // Division arithmetic; a zero divisor is swapped out to keep values known
  wire         dvs_zero = dvs == 16'h0000;
  wire [15:0]  dvs_safe = dvs_zero ? 16'h0001 : dvs;
  wire [31:0]  q32      = acc / {16'h0000, dvs_safe};
  wire [31:0]  r32      = acc % {16'h0000, dvs_safe};
  wire [15:0]  q16      = acc[15:0] / dvs_safe;
  wire [15:0]  r16      = acc[15:0] % dvs_safe;
  wire [31:0]  prod     = acc[15:0] * dvs;

  // Bits moved this cycle of a shift run
  wire [2:0]   step_n   = first ? FIRST_STEP : NEXT_STEP;
  wire [4:0]   step_k   = (rem > {2'b00, step_n}) ? {2'b00, step_n} : rem;
  wire [31:0]  shifted  = shift_right_select ? (acc >> step_k) : (acc << step_k);
  wire         shift_dn = rem == step_k;
  wire [36:0]  norm_out = norm_step(acc, rem, step_n);
  wire         norm_dn  = norm_out[36] || norm_out[4:0] == NORM_MAX;

  // Kind of multiply/divide chosen when byte 5 lands
  wire mdu_op_t start_op = (wseq == W_01234) ? OP_DIV32 :
                           (wseq == W_014)   ? OP_DIV16 :
                           (wseq == W_041)   ? OP_MUL   : OP_NONE;

  // Error sources: restart while armed, control rewrite or bytes 0-3 access mid-shift
  wire         retrig   = (wr_md0 && armed) || (wr_ctrl && busy)
                          || (busy && low_acc);

  // Final read of the watched read-out sequence
  wire         last_md5 = (mon_op == OP_DIV32 || mon_op == OP_DIV16)
                          && reg_sel == SEL_MD5;
  wire         last_md3 = (mon_op == OP_MUL || mon_op == OP_SHIFT)
                          && reg_sel == SEL_MD3;
  wire         final_rd = rd_en && armed && (last_md5 || last_md3);

  // Byte update: arithmetic, then shift step, then CPU write on top
  always_comb
  begin
    for (int i = 0; i < 6; i++)
      next_md[i] = md[i];
    case (pend)
      OP_DIV32:
      begin
        if (!dvs_zero)
        begin
          {next_md[3], next_md[2], next_md[1], next_md[0]} = q32;
          {next_md[5], next_md[4]} = r32[15:0];
        end
      end
      OP_DIV16:
      begin
        if (!dvs_zero)
        begin
          {next_md[1], next_md[0]} = q16;
          {next_md[5], next_md[4]} = r16;
        end
      end
      OP_MUL:
        {next_md[3], next_md[2], next_md[1], next_md[0]} = prod;
      default:
      begin
        // Shift engine owns bytes 0-3 while running
        if (run == R_SHIFT)
          {next_md[3], next_md[2], next_md[1], next_md[0]} = shifted;
        else if (run == R_NORM)
          {next_md[3], next_md[2], next_md[1], next_md[0]} = norm_out[36:5];
      end
    endcase
    // Writes to bytes 1-3 mid-shift are dropped; byte 0 aborts the run
    if (wr_en && reg_sel <= SEL_MD5 && !(busy && reg_sel != SEL_MD0
        && reg_sel <= SEL_MD3))
      next_md[reg_sel] = wr_data;
  end

  // Operand and result storage; nothing decays, results wait for the reader
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      for (int i = 0; i < 6; i++)
        md[i] <= MD_RST;
    else
      for (int i = 0; i < 6; i++)
        md[i] <= next_md[i];
  end

  // Write-order tracking; byte 0 always begins a new sequence
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      wseq <= W_IDLE;
    else if (wr_md0)
      wseq <= W_0;
    else if (wr_en)
      wseq <= seq_next(wseq, reg_sel);
  end

  // Multiply/divide launch: computed one cycle after the byte 5 write
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      pend <= OP_NONE;
    else if (wr_md5)
      pend <= start_op;
    else
      pend <= OP_NONE;
  end

  // Shift and normalize engine
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      run   <= R_IDLE;
      rem   <= SC_RST;
      first <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      // Every control write starts a run, even mid-run
      run   <= (wr_data[SC_MSB:0] == SC_RST) ? R_NORM : R_SHIFT;
      rem   <= wr_data[SC_MSB:0];
      first <= 1'b1;
    end
    else if (wr_md0)
      run   <= R_IDLE;
    else
    begin
      first <= 1'b0;
      case (run)
        R_NORM:
        begin
          rem <= norm_out[4:0];
          if (norm_dn)
            run <= R_IDLE;
        end
        R_SHIFT:
        begin
          rem <= rem - step_k;
          if (shift_dn)
            run <= R_IDLE;
        end
        default:
          run <= R_IDLE;
      endcase
    end
  end

  // Control fields; count reports the normalize total at its end
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      shift_right_select <= 1'b0;
      sc  <= SC_RST;
    end
    else if (wr_ctrl)
    begin
      shift_right_select <= wr_data[SLR_BIT];
      sc  <= wr_data[SC_MSB:0];
    end
    else if (run == R_NORM && norm_dn)
      sc  <= norm_out[4:0];
  end

  // Overflow: set or cleared by each operation, never by software
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      ovf <= 1'b0;
    else if (pend == OP_DIV32 || pend == OP_DIV16)
      ovf <= dvs_zero;
    else if (pend == OP_MUL)
      ovf <= prod[31:16] != 16'h0000;
    else if (wr_ctrl)
      ovf <= (wr_data[SC_MSB:0] == SC_RST) && md[3][7];
  end

  // Error flag: a set in the same cycle as the clearing read wins
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      err <= 1'b0;
    else
      err <= retrig || (err && !rd_ctrl);
  end

  // Monitor arming and the operation whose read-out is tracked
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      armed  <= 1'b0;
      mon_op <= OP_NONE;
    end
    else
    begin
      if (wr_md0)
        armed <= 1'b1;
      else if (final_rd)
        armed <= 1'b0;
      if (wr_md0)
        mon_op <= OP_NONE;
      else if (pend != OP_NONE)
        mon_op <= pend;
      else if (wr_ctrl)
        mon_op <= OP_SHIFT;
    end
  end

  // Read data, registered; unused selects read as zero
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      rd_data <= 8'h00;
    else if (rd_en && reg_sel <= SEL_MD5)
      rd_data <= md[reg_sel];
    else if (rd_ctrl)
      rd_data <= {err, ovf, shift_right_select, sc};
    else if (rd_en)
      rd_data <= 8'h00;
  end

endmodule // mdu_unit

// ===== testbench/mdu_unit_assertions.sv
// Port-level checker for the arithmetic coprocessor
`timescale 1ns/10ps
module mdu_unit_assertions
  import mdu_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rstn,
  input wire logic [2:0] reg_sel,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic [31:0] opnd; // Bytes 0-3 as last written
  logic [7:0]  ctl;  // Last control write
  wire  [31:0] shv = ctl[SLR_BIT] ? opnd >> ctl[4:0] : opnd << ctl[4:0];
  // Count of leading zeros; an all-zero word stops at the maximum
  function automatic logic [4:0] lzc(input logic [31:0] x);
    lzc = 5'h1F;
    for (int i = 0; i < 32; i++)
      if (x[i])
        lzc = 5'(31 - i);
  endfunction
  // Shadow of written operands; only valid when all four bytes were written
  always_ff @(posedge ref_clk or negedge rstn)
    if (!rstn)
    begin
      opnd <= 32'h0;
      ctl  <= 8'h00;
    end
    else if (wr_en && reg_sel < SEL_MD4)
      opnd[8*reg_sel +: 8] <= wr_data;
    else if (wr_en && reg_sel == SEL_CTRL)
      ctl <= wr_data;
  sequence wrs(logic [2:0] s);
    wr_en && reg_sel == s;
  endsequence
  sequence rds(logic [2:0] s);
    rd_en && reg_sel == s;
  endsequence
  sequence fill4;
    wrs(SEL_MD0) ##1 wrs(SEL_MD1) ##1 wrs(SEL_MD2) ##1 wrs(SEL_MD3);
  endsequence
  chk_rd_hold: assert property (!rd_en |=> $stable(rd_data))
    else $error("read data moved without a read");
  chk_mul_low: assert property (
    wrs(SEL_MD0) ##1 wrs(SEL_MD4) ##1 wrs(SEL_MD1) ##1 wrs(SEL_MD5) ##2 rds(SEL_MD0)
    |=> rd_data == 8'(32'({$past(wr_data, 4), $past(wr_data, 6)})
    * 32'({$past(wr_data, 3), $past(wr_data, 5)})))
    else $error("product low byte wrong");
  chk_div_zero: assert property (
    wrs(SEL_MD0) ##1 wrs(SEL_MD1) ##1 (wr_en && reg_sel == SEL_MD4 && wr_data == 8'h00)
    ##1 (wr_en && reg_sel == SEL_MD5 && wr_data == 8'h00) ##2 rds(SEL_CTRL)
    |=> rd_data[OVF_BIT])
    else $error("divide by zero left overflow clear");
  chk_retrig_err: assert property (
    wrs(SEL_MD0) ##1 wrs(SEL_MD0) ##1 rds(SEL_CTRL) |=> rd_data[ERR_BIT])
    else $error("restart did not flag an error");
  chk_err_clear: assert property (
    rds(SEL_CTRL) ##1 rds(SEL_CTRL) |=> !rd_data[ERR_BIT])
    else $error("error flag survived a read");
  chk_shift_val: assert property (
    fill4 ##1 (wr_en && reg_sel == SEL_CTRL && wr_data[4:0] != 5'h00)
    ##1 !wr_en [*6] ##1 rds(SEL_MD0) |=> rd_data == shv[7:0])
    else $error("shift result low byte wrong");
  chk_norm_val: assert property (
    fill4 ##1 (wr_en && reg_sel == SEL_CTRL && wr_data[4:0] == 5'h00)
    ##1 !wr_en [*6] ##1 rds(SEL_MD0) |=> rd_data == 8'(opnd << lzc(opnd)))
    else $error("normalize result low byte wrong");
  chk_mid_shift: assert property (
    (wr_en && reg_sel == SEL_CTRL && wr_data[4:0] == 5'h1F) ##1 rds(SEL_MD0)
    ##1 rds(SEL_CTRL) |=> rd_data[ERR_BIT])
    else $error("early operand read not flagged");
  cov_mul: cover property (wrs(SEL_MD4) ##1 wrs(SEL_MD1) ##1 wrs(SEL_MD5));
  cov_shift: cover property (wrs(SEL_CTRL) ##1 rds(SEL_MD0));
  cov_ctrl: cover property (rds(SEL_CTRL) ##1 rds(SEL_CTRL));
endmodule // mdu_unit_assertions
bind mdu_unit mdu_unit_assertions chk (.ref_clk, .rstn, .reg_sel, .wr_en, .rd_en, .wr_data,
  .rd_data);

// ===== testbench/mdu_cpu_model.sv
// CPU-side model issuing register writes and reads
`timescale 1ns/10ps
module mdu_cpu_model
  import mdu_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic [7:0] rd_data,
  output logic      [2:0] reg_sel,
  output logic            wr_en,
  output logic            rd_en,
  output logic      [7:0] wr_data
);
  // Idle bus at time zero: no strobe, unused select
  initial
  begin
    reg_sel = 3'h7;
    wr_en   = 1'b0;
    rd_en   = 1'b0;
    wr_data = 8'h00;
  end
  // One access per cycle, changed just after the edge
  task automatic acc(input logic w, input logic r, input logic [2:0] s, input logic [7:0] d);
    @(posedge ref_clk);
    wr_en   <= w;
    rd_en   <= r;
    reg_sel <= s;
    wr_data <= d;
  endtask
  // Idle cycles; data flips so a stale byte never looks valid
  task automatic gap(input int n);
    repeat (n) acc(1'b0, 1'b0, 3'h7, ~wr_data);
  endtask
  // Byte 0 leads; the select order picks the operation
  task automatic load(input logic [2:0] ord[$], input logic [47:0] v);
    foreach (ord[i])
      acc(1'b1, 1'b0, ord[i], ord[i] == SEL_CTRL ? v[47:40] : v[8*ord[i] +: 8]);
  endtask
  // Read one register; answer lands one edge after the strobe
  task automatic get(input logic [2:0] s, output logic [7:0] q);
    acc(1'b0, 1'b1, s, ~wr_data);
    gap(1);
    @(negedge ref_clk);
    q = rd_data;
  endtask
endmodule // mdu_cpu_model

// ===== testbench/tb_mdu_unit.sv
// Self-checking testbench for the arithmetic coprocessor
`timescale 1ns/10ps
module tb_mdu_unit;
  import mdu_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rstn    = 1'b0;
  logic [2:0]  reg_sel;
  logic        wr_en;
  logic        rd_en;
  logic [7:0]  wr_data;
  logic [7:0]  rd_data;
  logic [7:0]  q;
  logic [31:0] v;
  int          bad_count = 0;
  int          checked   = 0;
  // Operand tables: multiply pairs, shift/normalize words and results
  logic [15:0] ma[2]   = '{16'hFFFF, 16'h00FF};
  logic [15:0] mb[2]   = '{16'hFFFF, 16'h0101};
  logic [31:0] sv[7]   = '{32'h80000001, 32'h80000001, 32'h89ABCDEF, 32'h1, 32'h10000, 32'h0,
                           32'h80000000};
  logic [7:0]  sc[7]   = '{8'h21, 8'h1F, 8'h3F, 8'h04, 8'h00, 8'h00, 8'h00};
  logic [31:0] sx[7]   = '{32'h40000000, 32'h80000000, 32'h1, 32'h10, 32'h80000000, 32'h0,
                           32'h80000000};
  logic [7:0]  ectl[7] = '{8'h21, 8'h1F, 8'h3F, 8'h04, 8'h0F, 8'h1F, 8'h40};
  logic [7:0]  d16[4]  = '{8'h92, 8'h24, 8'h01, 8'h00};
  always #2 ref_clk = ~ref_clk;
  mdu_unit dut (.ref_clk(ref_clk), .rstn(rstn), .reg_sel(reg_sel), .wr_en(wr_en),
    .rd_en(rd_en), .wr_data(wr_data), .rd_data(rd_data));
  mdu_cpu_model cpu (.ref_clk(ref_clk), .rd_data(rd_data), .reg_sel(reg_sel), .wr_en(wr_en),
    .rd_en(rd_en), .wr_data(wr_data));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Bytes 0 to 3, byte 3 last so a multiply or shift monitor disarms
  task automatic rd32(output logic [31:0] r);
    for (int i = 0; i < 4; i++)
    begin
      cpu.get(3'(i), q);
      r[8*i +: 8] = q;
    end
  endtask
  task automatic summarize();
    if (bad_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    // Multiply: prompt read-out, then one after a long pause
    for (int i = 0; i < 2; i++)
    begin
      cpu.load({SEL_MD0, SEL_MD4, SEL_MD1, SEL_MD5}, {mb[i], 16'h0, ma[i]});
      cpu.gap(1 + 40 * i);
      rd32(v);
      chk(v, 32'(ma[i]) * 32'(mb[i]));
      cpu.get(SEL_CTRL, q);
      chk(q[OVF_BIT], i == 0);
    end
    cpu.load({SEL_MD0, SEL_MD1, SEL_MD2, SEL_MD3, SEL_MD4, SEL_MD5}, 48'h0100_1234_5678);
    cpu.gap(6);
    rd32(v);
    chk(v, 32'h00123456);
    cpu.get(SEL_MD4, q);
    chk(q, 8'h78);
    cpu.get(SEL_MD5, q);
    chk(q, 8'h00);
    cpu.load({SEL_MD0, SEL_MD1, SEL_MD4, SEL_MD5}, 48'h0007_0000_FFFF);
    cpu.gap(1);
    for (int i = 0; i < 4; i++)
    begin
      cpu.get(i < 2 ? 3'(i) : 3'(i + 2), q);
      chk(q, d16[i]);
    end
    // Divide by zero, then a restart read twice from control
    cpu.load({SEL_MD0, SEL_MD1, SEL_MD4, SEL_MD5}, 48'h0000_0000_1234);
    cpu.gap(1);
    cpu.get(SEL_CTRL, q);
    chk(q[OVF_BIT], 1'b1);
    cpu.load({SEL_MD0, SEL_MD0}, 48'h0);
    cpu.acc(1'b0, 1'b1, SEL_CTRL, 8'h00);
    cpu.get(SEL_CTRL, q);
    chk(q[ERR_BIT], 1'b0);
    // Shifts both ways, then normalize; error bit masked
    for (int i = 0; i < 7; i++)
    begin
      cpu.load({SEL_MD0, SEL_MD1, SEL_MD2, SEL_MD3, SEL_CTRL}, {sc[i], 8'h00, sv[i]});
      cpu.gap(6);
      rd32(v);
      chk(v, sx[i]);
      cpu.get(SEL_CTRL, q);
      chk(q & 8'h7F, ectl[i]);
    end
    // Operand read while a long shift still runs
    cpu.load({SEL_MD0, SEL_MD1, SEL_MD2, SEL_MD3, SEL_CTRL}, 48'h1F00_FFFF_FFFF);
    cpu.acc(1'b0, 1'b1, SEL_MD0, 8'h00);
    cpu.get(SEL_CTRL, q);
    chk(q[ERR_BIT], 1'b1);
    summarize();
  end
  // Guard against a hang
  initial
  begin
    repeat (100000) @(posedge ref_clk);
    bad_count++;
    summarize();
  end
endmodule // tb_mdu_unit
